//--- hw/status_byte_pkg.sv
// status byte and service request constants shared by the design files
// assumes: nothing beyond a systemverilog compiler
package status_byte_pkg;
	localparam int unsigned BYTE_W          = 8;
	localparam int unsigned QUES_W_DEF      = 16;
	localparam int unsigned OPER_W_DEF      = 16;
	localparam int unsigned EVSTAT_W        = 8;
	localparam int unsigned BIT_UNUSED0     = 0;
	localparam int unsigned BIT_UNUSED1     = 1;
	localparam int unsigned BIT_ERRQ        = 2;
	localparam int unsigned BIT_QUES        = 3;
	localparam int unsigned BIT_MSG         = 4;
	localparam int unsigned BIT_EVSUM       = 5;
	localparam int unsigned BIT_MAIN        = 6;
	localparam int unsigned BIT_OPER        = 7;
	localparam logic [7:0]  MASK_RESET      = 8'h00;
	localparam logic [7:0]  STATUS_RESET    = 8'h00;
	localparam logic [7:0]  RESP_RESET      = 8'h00;
	localparam logic [7:0]  MASK_USED       = 8'hbc;
	localparam logic [7:0]  STATUS_SRC_MASK = 8'hbc;
	localparam int unsigned RESP_LATENCY    = 1;
endpackage

//--- hw/summary_reduce.sv
// and-or reduction of an event vector with its enable vector
// assumes: both vectors are synchronous to the same clock
`timescale 1ns/1ps
`default_nettype none
module summary_reduce #(
	parameter int unsigned W = 8
) (
	input  wire logic [W-1:0] event_i,
	input  wire logic [W-1:0] enable_i,
	output wire logic         summary_o
);
	wire logic [W-1:0] hit;

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			assign hit[g] = event_i[g] & enable_i[g];
		end
	endgenerate

	assign summary_o = |hit;
endmodule
`default_nettype wire

//--- hw/status_byte_service_request.sv
// status byte, service request mask and service request generation
// assumes: command strobes are one-cycle pulses from a decoder synchronous to clk_i;
// lower status registers, event status register and error queue live elsewhere
`timescale 1ns/1ps
`default_nettype none

// How it works
// - bit 6 is set when any other masked status bit is set
// - status byte follows present summary levels, it latches nothing
// - status query and serial poll both return the current eight bits
// - mask bit 6 is ignored for summary and service request
// - an enabled status bit rising from 0 to 1 raises a service request
// - mask write command stores the mask, mask query returns it
// - bit 2 follows error queue not empty
// - with bit 2 enabled, each new error entry raises its own request
// - bit 3 is the or of enabled questionable events
// - bit 4 shows a message waiting in the output queue
// - bit 5 is the or of enabled event status bits
// - bit 7 is the or of enabled operation events
// - event summary sets when an enabled event status bit rises
module status_byte_service_request #(
	parameter int unsigned QUES_W = status_byte_pkg::QUES_W_DEF,
	parameter int unsigned OPER_W = status_byte_pkg::OPER_W_DEF
) (
	input  wire logic                                 clk_i,
	input  wire logic                                 rstn_i,
	input  wire logic                                 err_not_empty_i,
	input  wire logic                                 err_entry_i,
	input  wire logic [QUES_W-1:0]                    ques_event_i,
	input  wire logic [QUES_W-1:0]                    ques_enable_i,
	input  wire logic [OPER_W-1:0]                    oper_event_i,
	input  wire logic [OPER_W-1:0]                    oper_enable_i,
	input  wire logic [status_byte_pkg::EVSTAT_W-1:0] evstat_event_i,
	input  wire logic [status_byte_pkg::EVSTAT_W-1:0] evstat_enable_i,
	input  wire logic                                 msg_avail_i,
	input  wire logic                                 mask_write_i,
	input  wire logic [7:0]                           mask_data_i,
	input  wire logic                                 mask_query_i,
	input  wire logic                                 status_query_i,
	input  wire logic                                 serial_poll_i,
	output logic                                      resp_valid_o,
	output logic [7:0]                                resp_data_o,
	output logic [7:0]                                status_o,
	output logic                                      svc_req_o
);
	import status_byte_pkg::*;

	// ****************************************
	// reset release
	// ****************************************
	logic rst_meta_reg;
	logic rst_sync_reg;
	wire logic rstn;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rstn = rst_sync_reg;

	// ****************************************
	// summary inputs
	// ****************************************
	wire logic ques_sum;
	wire logic oper_sum;
	wire logic event_sum;

	summary_reduce #(.W(QUES_W)) u_ques (
		.event_i   (ques_event_i),
		.enable_i  (ques_enable_i),
		.summary_o (ques_sum)
	);
	summary_reduce #(.W(OPER_W)) u_oper (
		.event_i   (oper_event_i),
		.enable_i  (oper_enable_i),
		.summary_o (oper_sum)
	);
	// the event register latches its own events, so a level here covers a rise
	summary_reduce #(.W(EVSTAT_W)) u_event (
		.event_i   (evstat_event_i),
		.enable_i  (evstat_enable_i),
		.summary_o (event_sum)
	);

	// ****************************************
	// status byte and mask
	// ****************************************
	logic [7:0] mask_reg;
	logic [7:0] status_reg;
	logic       req_reg;
	logic       resp_valid_reg;
	logic [7:0] resp_data_reg;

	wire logic [7:0] mask_eff;
	wire logic [7:0] src_bits;
	wire logic       main_sum;
	wire logic [7:0] status_next;
	wire logic [7:0] rise;
	wire logic       req_next;
	wire logic       any_query;
	wire logic [7:0] resp_next;

	assign mask_eff = mask_reg & MASK_USED;
	// no latching here: every bit is rebuilt from the present levels
	assign src_bits = {oper_sum, 1'b0, event_sum, msg_avail_i, ques_sum,
		err_not_empty_i, 2'b00} & STATUS_SRC_MASK;
	assign main_sum = |(src_bits & mask_eff);
	assign status_next = src_bits | ({7'h00, main_sum} << BIT_MAIN);
	assign rise = status_next & ~status_reg & mask_eff;
	assign req_next = (|rise) | (err_entry_i & mask_eff[BIT_ERRQ]);
	assign any_query = status_query_i | serial_poll_i | mask_query_i;
	// status reads win over a mask read arriving in the same cycle
	assign resp_next = (status_query_i || serial_poll_i) ? status_next : mask_reg;

	always_ff @(posedge clk_i or negedge rstn)
	begin
		if (!rstn)
		begin
			mask_reg   <= MASK_RESET;
			status_reg <= STATUS_RESET;
			req_reg    <= 1'b0;
		end
		else
		begin
			if (mask_write_i)
				mask_reg <= mask_data_i;
			status_reg <= status_next;
			req_reg    <= req_next;
		end
	end

	always_ff @(posedge clk_i or negedge rstn)
	begin
		if (!rstn)
		begin
			resp_valid_reg <= 1'b0;
			resp_data_reg  <= RESP_RESET;
		end
		else
		begin
			resp_valid_reg <= any_query;
			if (any_query)
				resp_data_reg <= resp_next;
		end
	end

	assign status_o     = status_reg;
	assign svc_req_o    = req_reg;
	assign resp_valid_o = resp_valid_reg;
	assign resp_data_o  = resp_data_reg;

	// ****************************************
	// checks
	// ****************************************
	sequence s_enabled_rise;
		rise != 8'h00;
	endsequence
	sequence s_request;
		##1 svc_req_o;
	endsequence

	property p_main_sum;
		@(posedge clk_i) disable iff (!rstn)
		status_o[BIT_MAIN] == |(status_o & $past(mask_reg) & MASK_USED);
	endproperty
	a_main_sum: assert property (p_main_sum) else $error("main summary wrong");

	property p_follow;
		@(posedge clk_i) disable iff (!rstn)
		##1 (status_o[BIT_MSG] == $past(msg_avail_i))
			&& (status_o[BIT_ERRQ] == $past(err_not_empty_i));
	endproperty
	a_follow: assert property (p_follow) else $error("status byte not live");

	property p_status_read;
		@(posedge clk_i) disable iff (!rstn)
		(status_query_i || serial_poll_i) |=> resp_valid_o && resp_data_o == status_o;
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_mask_ignored;
		@(posedge clk_i) disable iff (!rstn)
		$stable(src_bits) && $stable(mask_reg & MASK_USED) |-> $stable(main_sum);
	endproperty
	a_mask_ignored: assert property (p_mask_ignored) else $error("mask bit 6 used");

	property p_rise_req;
		@(posedge clk_i) disable iff (!rstn)
		s_enabled_rise |-> s_request;
	endproperty
	a_rise_req: assert property (p_rise_req) else $error("missed request");

	// write, one quiet cycle, then a plain mask read must return the written byte
	property p_mask_rw;
		@(posedge clk_i) disable iff (!rstn)
		mask_write_i ##1 !mask_write_i ##1 (mask_query_i && !status_query_i && !serial_poll_i)
			|=> resp_data_o == $past(mask_data_i, 3);
	endproperty
	a_mask_rw: assert property (p_mask_rw) else $error("mask readback wrong");

	property p_err_entry;
		@(posedge clk_i) disable iff (!rstn)
		err_entry_i && mask_reg[BIT_ERRQ] |=> svc_req_o;
	endproperty
	a_err_entry: assert property (p_err_entry) else $error("error entry no request");

	property p_summaries;
		@(posedge clk_i) disable iff (!rstn)
		##1 status_o[BIT_QUES] == $past(ques_sum) && status_o[BIT_OPER] == $past(oper_sum)
			&& status_o[BIT_EVSUM] == $past(event_sum);
	endproperty
	a_summaries: assert property (p_summaries) else $error("summary bit wrong");

	property p_unused_zero;
		@(posedge clk_i) disable iff (!rstn)
		status_o[1:0] == 2'b00 && !(svc_req_o && !$past(|rise) && !$past(err_entry_i));
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bits active");
endmodule
`default_nettype wire

//--- tb/ctrl_model.sv
// remote controller model: mask and status commands as one-cycle strobes
// assumes: cmd is called at a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	input  wire logic       clk_i,
	output logic            mask_write_o,
	output logic [7:0]      mask_data_o,
	output logic            mask_query_o,
	output logic            status_query_o,
	output logic            serial_poll_o
);
	// ********
	// commands
	// ********
	initial
	begin
		{mask_write_o, mask_query_o, status_query_o, serial_poll_o} = 4'h0;
		mask_data_o = 8'h00;
	end
	// data shows its inverse once released, so a stale byte is never read as valid
	task automatic cmd(input logic [3:0] k, input logic [7:0] d);
		{mask_write_o, mask_query_o, status_query_o, serial_poll_o} = k;
		mask_data_o = d;
		@(negedge clk_i);
		{mask_write_o, mask_query_o, status_query_o, serial_poll_o} = 4'h0;
		mask_data_o = ~d;
	endtask
endmodule
`default_nettype wire

//--- tb/status_byte_service_request_test.sv
// bench for the status byte and service request block
// assumes: the controller model drives the command strobes
`timescale 1ns/1ps
`default_nettype none
module status_byte_service_request_test;
	import status_byte_pkg::*;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        ne, ent, mav, sw, sq, stq, sp, rv, rq;
	logic [15:0] qe, qn, oe, on, x;
	logic [7:0]  ee, en, sd, rd, st, mask, prev, es;
	logic [15:0] rs = 16'haf48;
	logic [7:0]  expq[$];
	int          error_cnt = 0;
	int          compares = 0;
	always #2.5 clk_i = ~clk_i;
	status_byte_service_request i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.err_not_empty_i(ne), .err_entry_i(ent), .ques_event_i(qe), .ques_enable_i(qn),
		.oper_event_i(oe), .oper_enable_i(on), .evstat_event_i(ee), .evstat_enable_i(en),
		.msg_avail_i(mav), .mask_write_i(sw), .mask_data_i(sd), .mask_query_i(sq),
		.status_query_i(stq), .serial_poll_i(sp), .resp_valid_o(rv), .resp_data_o(rd),
		.status_o(st), .svc_req_o(rq));
	ctrl_model i_ctrl (.clk_i(clk_i), .mask_write_o(sw), .mask_data_o(sd),
		.mask_query_o(sq), .status_query_o(stq), .serial_poll_o(sp));
	// ********
	// helpers
	// ********
	function automatic logic [15:0] lf();
		rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
		return rs;
	endfunction
	function automatic logic [7:0] calc();
		logic [7:0] b;
		b = {|(oe & on), 1'b0, |(ee & en), mav, |(qe & qn), ne, 2'b00};
		b[6] = |(b & mask & 8'hbc);
		return b;
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one-hot enables keep the summaries toggling instead of stuck high
	task automatic step(input logic [3:0] k, input logic [7:0] d, input logic [1:0] m);
		logic [15:0] y;
		@(negedge clk_i);
		y = lf();
		if (m[0])
		begin
			qe = y & lf();
			qn = 16'h0001 << y[3:0];
			oe = lf() & lf();
			on = 16'h0001 << y[7:4];
			ee = y[15:8] & y[7:0];
			en = 8'h01 << y[10:8];
			ent = y[11];
			ne = y[12] | y[11];
			mav = y[13];
		end
		if (m[1])
			{ent, ne} = 2'b11;
		es = calc();
		if (k[1] | k[0])
			expq.push_back(es);
		else if (k[2])
			expq.push_back(mask);
		i_ctrl.cmd(k, d);
		chk("status", st, es);
		chk("request", {7'h00, rq},
			{7'h00, |(es & ~prev & mask & MASK_USED) | (ent & mask[BIT_ERRQ])});
		prev = es;
		if (k[3])
			mask = d;
		ent = 1'b0;
	endtask
	always @(negedge clk_i)
		if (rv === 1'b1)
			chk("resp", rd, expq.size() > 0 ? expq.pop_front() : 8'hxx);
	// ********
	// sequence
	// ********
	initial
	begin
		{ne, ent, mav, qe, qn, oe, on, ee, en} = '0;
		mask = MASK_RESET;
		prev = 8'h00;
		repeat (6) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (3) @(negedge clk_i);
		chk("rst", st, STATUS_RESET);
		step(4'h4, 8'h00, 2'b00);
		step(4'h8, 8'h44, 2'b00);
		step(4'h4, 8'h00, 2'b00);
		step(4'h1, 8'h00, 2'b10);
		step(4'h0, 8'h00, 2'b10);
		// the controller answers the error request by draining the error queue
		ne = 1'b0;
		step(4'h1, 8'h00, 2'b00);
		step(4'hc, 8'hff, 2'b00);
		step(4'h6, 8'h00, 2'b00);
		step(4'h4, 8'h00, 2'b00);
		repeat (200)
		begin
			x = lf();
			step(x[3:0], x[15:8], 2'b01);
		end
		step(4'h0, 8'h00, 2'b00);
		// a query that never got its answer leaves a note behind
		chk("pending", 8'(expq.size()), 8'h00);
		finish_test();
	end
	initial
	begin
		#20000;
		error_cnt++;
		finish_test();
	end
endmodule
`default_nettype wire
